// *** dpsct_host_port.sv ***
// host side controller for one port of an asynchronous dual-port sram
`default_nettype none
`timescale 1ns/1ps
// Contract
// - array or semaphore select held through write
// - a control high while address changes
// - never drive while device still drives
// - write pulse covers turnoff plus setup
// - streaming writes keep enables low
// - streaming address stable one write cycle
// - setup and recovery only at turnarounds; code adds an address and end cycle to every non-streamed write
// - address bits change together, low skew
// - address edges fast enough
// - inhibit asserted before write starts
// - write held after inhibit release
module dpsct_host_port (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  // user request side
  input  wire logic                        req_valid_i,
  output logic                             req_ready_o,
  input  wire logic                        req_write_i,
  input  wire logic                        req_sem_i,
  input  wire logic                        req_stream_i,
  input  wire logic [dpsct_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [dpsct_pkg::DATA_W-1:0] req_wdata_i,
  input  wire logic [dpsct_pkg::LANE_W-1:0] req_lane_en_i,
  input  wire logic                        inhibit_i,
  output logic                             resp_valid_o,
  output logic [dpsct_pkg::DATA_W-1:0]     resp_rdata_o,
  output logic                             resp_sem_o,
  output logic                             resp_sem_agree_o,
  // sram pins
  output logic [dpsct_pkg::ADDR_W-1:0]     addr_o,
  output logic                             select_low_active_n_o,
  output logic                             select_high_active_o,
  output logic                             rw_o,
  output logic                             output_enable_n_o,
  output logic [dpsct_pkg::LANE_W-1:0]     byte_lane_enable_n_o,
  output logic                             semaphore_select_n_o,
  output logic                             write_inhibit_n_o,
  input  wire logic [dpsct_pkg::DATA_W-1:0] dq_i,
  output logic [dpsct_pkg::DATA_W-1:0]     dq_o,
  output logic                             dq_oe_o
);

  // ***************************************************************
  // state and registers
  // ***************************************************************
  dpsct_pkg::dpsct_state_t state_q;
  dpsct_pkg::dpsct_state_t state_d;

  logic                             sem_q;
  logic                             stream_q;
  logic [dpsct_pkg::LANE_W-1:0]     lane_q;
  logic [dpsct_pkg::ADDR_W-1:0]     addr_q;
  logic [dpsct_pkg::DATA_W-1:0]     wdata_q;
  logic                             ce_act_q;
  logic                             sem_act_q;
  logic                             oe_act_q;
  logic                             lane_act_q;
  logic                             wr_act_q;
  logic                             dq_oe_q;
  logic                             busy_n_q;
  logic                             resp_valid_q;
  logic [dpsct_pkg::DATA_W-1:0]     rdata_q;
  logic                             rsem_q;
  logic                             ragree_q;

  // ***************************************************************
  // timers
  // ***************************************************************
  logic                         ph_load;
  logic [dpsct_pkg::CNT_W-1:0]  ph_count;
  logic                         ph_done;
  logic                         gap_load;
  logic [dpsct_pkg::CNT_W-1:0]  gap_count;
  logic                         gap_done;
  logic                         hold_done;

  dpsct_timer u_phase (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (ph_load),
    .count_i   (ph_count),
    .done_o    (ph_done)
  );

  // bus turnaround and semaphore write-to-read gap
  dpsct_timer u_gap (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (gap_load),
    .count_i   (gap_count),
    .done_o    (gap_done)
  );

  // reloads while inhibit is low, runs out after release
  dpsct_timer u_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (~busy_n_q),
    .count_i   (dpsct_pkg::C_INH_HOLD),
    .done_o    (hold_done)
  );

  // ***************************************************************
  // decode
  // ***************************************************************
  wire in_idle    = (state_q == dpsct_pkg::ST_IDLE);
  wire in_rd_addr = (state_q == dpsct_pkg::ST_RD_ADDR);
  wire in_rd_wait = (state_q == dpsct_pkg::ST_RD_WAIT);
  wire in_wr_addr = (state_q == dpsct_pkg::ST_WR_ADDR);
  wire in_pulse   = (state_q == dpsct_pkg::ST_WR_PULSE);
  wire in_wr_end  = (state_q == dpsct_pkg::ST_WR_END);

  wire idle_take  = in_idle & req_valid_i;
  // pulse may close only when long enough and clear of inhibit hold
  wire pulse_end  = in_pulse & ph_done & hold_done & busy_n_q;
  // another array write chained without raising the enables
  wire stream_go  = pulse_end & stream_q & ~sem_q & req_valid_i &
                    req_write_i & ~req_sem_i;
  wire take       = idle_take | stream_go;
  // semaphore reads wait out the write-to-read gap, writes the bus off
  wire rd_start   = in_rd_addr & (gap_done | ~sem_q);
  wire wr_start   = in_wr_addr & gap_done;
  wire rd_sample  = in_rd_wait & ph_done;

  // inhibit may only newly assert outside a write pulse
  wire busy_n_d   = inhibit_i ? (busy_n_q & in_pulse) : 1'b1;

  wire [dpsct_pkg::SEM_GRP1_MSB-dpsct_pkg::SEM_GRP1_LSB:0] sem_g1 =
    dq_i[dpsct_pkg::SEM_GRP1_MSB:dpsct_pkg::SEM_GRP1_LSB];
  wire [dpsct_pkg::SEM_GRP0_MSB-dpsct_pkg::SEM_GRP0_LSB:0] sem_g0 =
    dq_i[dpsct_pkg::SEM_GRP0_MSB:dpsct_pkg::SEM_GRP0_LSB];
  wire sem_agree  = (&{sem_g1, sem_g0}) | ~(|{sem_g1, sem_g0});

  assign req_ready_o = in_idle | stream_go;

  // ***************************************************************
  // timer loads
  // ***************************************************************
  assign ph_load  = rd_start | wr_start | stream_go;
  assign ph_count = rd_start  ? dpsct_pkg::C_RD_ACCESS :
                    stream_go ? dpsct_pkg::C_WR_STREAM :
                                dpsct_pkg::C_WR_PULSE;

  assign gap_load  = rd_sample | in_wr_end;
  assign gap_count = rd_sample ? dpsct_pkg::C_BUS_OFF :
                                 dpsct_pkg::C_SEM_GAP;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      dpsct_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          state_d = req_write_i ? dpsct_pkg::ST_WR_ADDR
                                : dpsct_pkg::ST_RD_ADDR;
        end
      end
      dpsct_pkg::ST_RD_ADDR: begin
        if (rd_start) begin
          state_d = dpsct_pkg::ST_RD_WAIT;
        end
      end
      dpsct_pkg::ST_RD_WAIT: begin
        if (rd_sample) begin
          state_d = dpsct_pkg::ST_IDLE;
        end
      end
      dpsct_pkg::ST_WR_ADDR: begin
        if (wr_start) begin
          state_d = dpsct_pkg::ST_WR_PULSE;
        end
      end
      dpsct_pkg::ST_WR_PULSE: begin
        if (pulse_end && !stream_go) begin
          state_d = dpsct_pkg::ST_WR_END;
        end
      end
      dpsct_pkg::ST_WR_END: begin
        state_d = dpsct_pkg::ST_IDLE;
      end
      default: begin
        state_d = dpsct_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // request capture
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sem_q    <= 1'b0;
      stream_q <= 1'b0;
      lane_q   <= '0;
      addr_q   <= '0;
      wdata_q  <= '0;
    end else if (take) begin
      sem_q    <= req_sem_i;
      stream_q <= req_stream_i;
      lane_q   <= req_lane_en_i;
      // all address bits from one flop bank on one edge
      addr_q   <= req_addr_i;
      wdata_q  <= req_wdata_i;
    end
  end

  // ***************************************************************
  // pin controls
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ce_act_q   <= 1'b0;
      sem_act_q  <= 1'b0;
      oe_act_q   <= 1'b0;
      lane_act_q <= 1'b0;
      wr_act_q   <= 1'b0;
    end else if (rd_start) begin
      // all read enables on the same edge
      ce_act_q   <= ~sem_q;
      sem_act_q  <= sem_q;
      oe_act_q   <= 1'b1;
      lane_act_q <= 1'b1;
    end else if (wr_start) begin
      // select and write strobe fall together: device stays off
      ce_act_q   <= ~sem_q;
      sem_act_q  <= sem_q;
      lane_act_q <= 1'b1;
      wr_act_q   <= 1'b1;
    end else if (rd_sample || (pulse_end && !stream_go)) begin
      // outside a streamed run, address only moves after this, with the controls high
      ce_act_q   <= 1'b0;
      sem_act_q  <= 1'b0;
      oe_act_q   <= 1'b0;
      lane_act_q <= 1'b0;
      wr_act_q   <= 1'b0;
    end
  end

  // write data; held one cycle past the write strobe rise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_oe_q <= 1'b0;
    end else if (wr_start) begin
      dq_oe_q <= 1'b1;
    end else if (in_wr_end) begin
      dq_oe_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_n_q <= 1'b1;
    end else begin
      busy_n_q <= busy_n_d;
    end
  end

  // ***************************************************************
  // read response
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_valid_q <= 1'b0;
      rdata_q      <= '0;
      rsem_q       <= 1'b0;
      ragree_q     <= 1'b0;
    end else begin
      resp_valid_q <= rd_sample;
      if (rd_sample) begin
        rdata_q  <= dq_i;
        rsem_q   <= dq_i[dpsct_pkg::SEM_VAL_BIT];
        ragree_q <= sem_agree;
      end
    end
  end

  // ***************************************************************
  // state register and outputs
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= dpsct_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign addr_o                = addr_q;
  assign select_low_active_n_o = ~ce_act_q;
  assign select_high_active_o  = ce_act_q;
  // strobe low through a streamed run, data pins stay driven
  assign rw_o                  = ~wr_act_q;
  // output enable never low during writes
  assign output_enable_n_o     = ~oe_act_q;
  assign byte_lane_enable_n_o  = ~(lane_q & {dpsct_pkg::LANE_W{lane_act_q}});
  assign semaphore_select_n_o  = ~sem_act_q;
  assign write_inhibit_n_o     = busy_n_q;
  assign dq_o                  = wdata_q;
  assign dq_oe_o               = dq_oe_q;
  assign resp_valid_o          = resp_valid_q;
  assign resp_rdata_o          = rdata_q;
  assign resp_sem_o            = rsem_q;
  assign resp_sem_agree_o      = ragree_q;

endmodule : dpsct_host_port
`default_nettype wire

// *** dpsct_host_port_sva.sv ***
// pin timing assertions for the dual-port sram host controller
`timescale 1ns/1ps
`default_nettype none
module dpsct_host_port_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic resp_valid_o,
  input wire logic select_low_active_n_o,
  input wire logic select_high_active_o,
  input wire logic rw_o,
  input wire logic output_enable_n_o,
  input wire logic semaphore_select_n_o,
  input wire logic write_inhibit_n_o,
  input wire logic dq_oe_o
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_excl;
    !(!select_low_active_n_o && !semaphore_select_n_o);
  endproperty
  a_excl: assert property (p_excl) else $error("both selects on");
  property p_pair;
    select_high_active_o == !select_low_active_n_o;
  endproperty
  a_pair: assert property (p_pair) else $error("select pins differ");
  property p_turn;
    $rose(output_enable_n_o) |-> !dq_oe_o [*2];
  endproperty
  a_turn: assert property (p_turn) else $error("dq driven too soon");
  property p_pulse;
    $fell(rw_o) |-> !rw_o [*5];
  endproperty
  a_pulse: assert property (p_pulse) else $error("write too short");
  property p_drv;
    !rw_o |-> dq_oe_o;
  endproperty
  a_drv: assert property (p_drv) else $error("dq not driven");
  property p_oe;
    !rw_o |-> output_enable_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("oe low in write");
  property p_rel;
    $rose(output_enable_n_o) |-> select_low_active_n_o && semaphore_select_n_o;
  endproperty
  a_rel: assert property (p_rel) else $error("enables apart");
  property p_acc;
    $fell(output_enable_n_o) |-> !output_enable_n_o [*5] ##1
      (output_enable_n_o && resp_valid_o) ##1 !resp_valid_o;
  endproperty
  a_acc: assert property (p_acc) else $error("read timing off");
  property p_inh;
    !write_inhibit_n_o && !rw_o |=> !rw_o;
  endproperty
  a_inh: assert property (p_inh) else $error("write ended inhibited");
  property p_hold;
    $rose(write_inhibit_n_o) && !rw_o |-> !rw_o [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("hold after inhibit");
  c_read: cover property ($fell(output_enable_n_o));
  c_write: cover property ($fell(rw_o));
  c_sem: cover property (!semaphore_select_n_o && !rw_o);
  c_inh: cover property ($rose(write_inhibit_n_o) && !rw_o);
endmodule : dpsct_host_port_sva
bind dpsct_host_port dpsct_host_port_sva u_sva (.ref_clk_i, .rst_i,
  .resp_valid_o, .select_low_active_n_o, .select_high_active_o, .rw_o,
  .output_enable_n_o, .semaphore_select_n_o, .write_inhibit_n_o, .dq_oe_o);
`default_nettype wire

// *** dpsct_pkg.sv ***
// constants, timing counts and state type for the dual-port sram host port
`default_nettype none
package dpsct_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int LANE_W = 4;
  localparam int CNT_W  = 8;

  // semaphore value groups on the data pins
  localparam int SEM_GRP0_LSB = 0;
  localparam int SEM_GRP0_MSB = 8;
  localparam int SEM_GRP1_LSB = 18;
  localparam int SEM_GRP1_MSB = 26;
  localparam int SEM_VAL_BIT  = 0;

  // ***************************************************************
  // clock and pin timing, slowest speed grade, in ns
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 4;

  localparam int T_AA_NS   = 15;
  localparam int T_ACE_NS  = 15;
  localparam int T_ABE_NS  = 7;
  localparam int T_AOE_NS  = 7;
  localparam int T_HZ_NS   = 8;
  localparam int T_WC_NS   = 15;
  localparam int T_EW_NS   = 12;
  localparam int T_WP_NS   = 12;
  localparam int T_WZ_NS   = 8;
  localparam int T_SWRD_NS = 5;
  localparam int T_DDD_NS  = 20;
  localparam int DATA_VALID_TO_END_TIME_NS   = 10;
  localparam int WRITE_HOLD_AFTER_INHIBIT_NS = 12;

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  // least time, rounded up, never below one cycle
  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    cyc_min = (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam logic [CNT_W-1:0] C_RD_ACCESS = CNT_W'(cyc_min(
    max2(max2(T_AA_NS, T_ACE_NS), max2(T_ABE_NS, T_AOE_NS))));
  localparam logic [CNT_W-1:0] C_BUS_OFF   = CNT_W'(cyc_min(T_HZ_NS));
  localparam logic [CNT_W-1:0] C_WR_PULSE  = CNT_W'(cyc_min(
    max2(max2(T_WP_NS, T_EW_NS),
         T_WZ_NS + DATA_VALID_TO_END_TIME_NS)));
  localparam logic [CNT_W-1:0] C_WR_STREAM = CNT_W'(cyc_min(
    max2(T_WC_NS, DATA_VALID_TO_END_TIME_NS)));
  localparam logic [CNT_W-1:0] C_SEM_GAP   = CNT_W'(cyc_min(T_SWRD_NS));
  localparam logic [CNT_W-1:0] C_INH_HOLD  = CNT_W'(cyc_min(
    WRITE_HOLD_AFTER_INHIBIT_NS));
  localparam logic [CNT_W-1:0] C_XPORT     = CNT_W'(cyc_min(T_DDD_NS));

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_WAIT,
    ST_WR_ADDR,
    ST_WR_PULSE,
    ST_WR_END
  } dpsct_state_t;

endpackage : dpsct_pkg
`default_nettype wire

// *** dpsct_sram_model.sv ***
// behavioural sram port answering the host controller
`timescale 1ns/1ps
`default_nettype none
module dpsct_sram_model (
  input  wire logic        ref_clk_i,
  input  wire logic [18:0] addr_i,
  input  wire logic        sel_n_i,
  input  wire logic        sel_i,
  input  wire logic        rw_i,
  input  wire logic        oe_n_i,
  input  wire logic [3:0]  lane_n_i,
  input  wire logic        sem_n_i,
  input  wire logic        inh_n_i,
  input  wire logic [35:0] d_i,
  input  wire logic        d_oe_i,
  output logic      [35:0] q_o
);
  // ********
  // array, flag, outputs
  // ********
  logic [35:0] mem [logic [18:0]];
  logic [35:0] last_q = '0;
  logic        flag_q = 1'b1;
  logic [2:0]  acc_q = '0;
  logic        arr;
  logic        semaphore_select_n;
  logic        rd;
  assign arr = !sel_n_i && sel_i && sem_n_i;
  assign semaphore_select_n = !sem_n_i && sel_n_i && !sel_i;
  assign rd = (arr || semaphore_select_n) && rw_i && !oe_n_i && lane_n_i != 4'hF;
  always_comb begin
    q_o = ~last_q;
    if (rd && acc_q >= 3'd4 && semaphore_select_n)
      q_o = {9'h000, {9{flag_q}}, 9'h000, {9{flag_q}}};
    else if (rd && acc_q >= 3'd4 && mem.exists(addr_i))
      q_o = mem[addr_i];
  end
  always @(posedge ref_clk_i) begin
    last_q <= q_o;
    acc_q <= !rd ? 3'd0 : (acc_q == 3'd7 ? acc_q : acc_q + 3'd1);
    if (!rw_i && inh_n_i && d_oe_i) begin
      for (int b = 0; b < 4; b++)
        if (arr && !lane_n_i[b]) mem[addr_i][9*b+:9] <= d_i[9*b+:9];
      if (semaphore_select_n) flag_q <= d_i[0];
    end
  end
endmodule : dpsct_sram_model
`default_nettype wire

// *** dpsct_timer.sv ***
// down counter giving a done level a loaded number of cycles later
`default_nettype none
`timescale 1ns/1ps
module dpsct_timer (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       load_i,
  input  wire logic [dpsct_pkg::CNT_W-1:0] count_i,
  output logic                            done_o
);

  logic [dpsct_pkg::CNT_W-1:0] cnt_q;
  logic [dpsct_pkg::CNT_W-1:0] cnt_d;

  assign cnt_d  = load_i ? count_i :
                  (done_o ? cnt_q : cnt_q - dpsct_pkg::CNT_W'(1));
  assign done_o = (cnt_q == '0);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : dpsct_timer
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the dual-port sram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ********
  // signals, instances, checker of reads
  // ********
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0, req_write_i = 1'b0, req_sem_i = 1'b0;
  logic        req_stream_i = 1'b0, inhibit_i = 1'b0;
  logic [18:0] req_addr_i = '0, addr_o;
  logic [35:0] req_wdata_i = '0, resp_rdata_o, dq_i, dq_o;
  logic [3:0]  req_lane_en_i = '0, byte_lane_enable_n_o;
  logic        req_ready_o, resp_valid_o, resp_sem_o, resp_sem_agree_o;
  logic        select_low_active_n_o, select_high_active_o, rw_o, dq_oe_o;
  logic        output_enable_n_o, semaphore_select_n_o, write_inhibit_n_o;
  logic [38:0] exp_q [$];
  logic [35:0] sh [logic [18:0]];
  logic [18:0] addr_tbl [6];
  int          n_fail = 0, samples_checked = 0;

  always #2 ref_clk_i = ~ref_clk_i;
  dpsct_host_port u_dpsct_host_port (.*);
  dpsct_sram_model u_dpsct_sram_model (.ref_clk_i(ref_clk_i),
    .addr_i(addr_o), .sel_n_i(select_low_active_n_o),
    .sel_i(select_high_active_o), .rw_i(rw_o), .oe_n_i(output_enable_n_o),
    .lane_n_i(byte_lane_enable_n_o), .sem_n_i(semaphore_select_n_o),
    .inh_n_i(write_inhibit_n_o), .d_i(dq_o), .d_oe_i(dq_oe_o), .q_o(dq_i));

  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic req(input logic w, s, st, input logic [18:0] a,
                     input logic [35:0] d, input logic [3:0] l);
    logic r;
    int   n;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_sem_i <= s;
    req_stream_i <= st;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_lane_en_i <= l;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      r = req_ready_o;
      @(posedge ref_clk_i);
      n++;
    end while (r !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, r);
    end
    req_valid_i <= 1'b0;
  endtask : req

  task automatic wr(input logic [18:0] a, input logic [35:0] d,
                    input logic [3:0] l, input logic st);
    for (int b = 0; b < 4; b++) if (l[b]) sh[a][9*b+:9] = d[9*b+:9];
    req(1'b1, 1'b0, st, a, d, l);
  endtask : wr

  task automatic rd(input logic [18:0] a);
    exp_q.push_back({1'b0, 2'b00, sh[a]});
    req(1'b0, 1'b0, 1'b0, a, '0, 4'hF);
  endtask : rd

  always @(negedge ref_clk_i) if (resp_valid_o === 1'b1) begin
    logic [38:0] e;
    e = exp_q.size() ? exp_q.pop_front() : '1;
    samples_checked++;
    if (resp_rdata_o !== e[35:0] || (e[38] && {resp_sem_agree_o,
        resp_sem_o} !== e[37:36])) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e,
               {resp_sem_agree_o, resp_sem_o, resp_rdata_o});
    end
  end

  initial begin
    #(4 * 5000);
    n_fail++;
    close_out();
  end

  // ********
  // scenarios
  // ********
  initial begin
    logic [35:0] d;
    d = 36'($urandom(66));
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    addr_tbl[0] = 19'h0_0000;
    addr_tbl[1] = 19'h7_FFFF;
    for (int i = 2; i < 6; i++) addr_tbl[i] = 19'($urandom);
    for (int i = 0; i < 6; i++)
      wr(addr_tbl[i], {4'($urandom), $urandom}, 4'hF, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = {4'($urandom), $urandom};
      wr(addr_tbl[i], d, 4'($urandom) | 4'h1, 1'b0);
    end
    for (int i = 0; i < 6; i++) rd(addr_tbl[i]);
    for (int i = 3; i < 6; i++)
      wr(addr_tbl[i], {4'($urandom), $urandom}, 4'hF, i < 5);
    for (int i = 3; i < 6; i++) rd(addr_tbl[i]);
    inhibit_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    wr(addr_tbl[2], {4'($urandom), $urandom}, 4'hF, 1'b0);
    repeat (12) @(posedge ref_clk_i);
    inhibit_i <= 1'b0;
    rd(addr_tbl[2]);
    for (int v = 0; v < 2; v++) begin
      req(1'b1, 1'b1, 1'b0, 19'h0_0003, 36'(v), 4'hF);
      exp_q.push_back({1'b1, 1'b1, 1'(v), 9'h000, {9{1'(v)}}, 9'h000,
                       {9{1'(v)}}});
      req(1'b0, 1'b1, 1'b0, 19'h0_0003, '0, 4'hF);
    end
    for (int i = 0; i < 12; i++) begin
      d = {4'($urandom), $urandom};
      if ($urandom % 2) wr(addr_tbl[$urandom % 6], d, 4'hF, 1'b0);
      else rd(addr_tbl[$urandom % 6]);
    end
    repeat (40) @(posedge ref_clk_i);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 0, exp_q.size());
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
